// >>> hdl/oemc_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "oemc_regs.svh"

module oemc_channel (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              op_wr_i,
	input  wire logic [7:0]        op_data_i,
	input  wire logic              bus_mode_i,
	output var  oemc_pkg::oemc_chan_t chan_o
);
	import oemc_pkg::*;

	oemc_chan_t st;
	oemc_chan_t next_st;
	logic [1:0] en_f;
	logic [1:0] mg_f;

	assign en_f = op_data_i[`OEMC_EN_MSB:`OEMC_EN_LSB];
	assign mg_f = op_data_i[`OEMC_MARGIN_MSB:`OEMC_MARGIN_LSB];

	always_comb begin
		next_st          = st;
		next_st.imm_off  = 1'b0;
		next_st.soft_off = 1'b0;
		next_st.ramp_up  = 1'b0;
		if (op_wr_i) begin
			next_st.op = op_data_i;
			// enable field only acts in bus mode
			if (bus_mode_i) begin
				case (en_f)
					`OEMC_EN_IMM_OFF: begin
						if (st.on) begin
							next_st.on      = 1'b0;
							next_st.imm_off = 1'b1;
						end
					end
					`OEMC_EN_SOFT_OFF: begin
						if (st.on) begin
							next_st.on       = 1'b0;
							next_st.soft_off = 1'b1;
						end
					end
					`OEMC_EN_ON: begin
						if (!st.on) begin
							next_st.on      = 1'b1;
							next_st.ramp_up = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			case (mg_f)
				`OEMC_MG_NOMINAL: next_st.target = OEMC_TGT_NOMINAL;
				`OEMC_MG_LOW:     next_st.target = OEMC_TGT_LOW;
				`OEMC_MG_HIGH:    next_st.target = OEMC_TGT_HIGH;
				default:          next_st.target = st.target;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st <= '{on: 1'b0, target: OEMC_TGT_NOMINAL, imm_off: 1'b0, soft_off: 1'b0,
				ramp_up: 1'b0, op: `OEMC_OP_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign chan_o = st;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_immediate_off: assert property (
		op_wr_i && bus_mode_i && en_f == 2'h0 && st.on |=> !st.on && st.imm_off ##1 !st.imm_off)
		else $error("immediate off not taken");
	chk_soft_off: assert property (
		op_wr_i && bus_mode_i && en_f == 2'h1 && st.on |=> !st.on && st.soft_off && !st.imm_off)
		else $error("soft off not taken");
	chk_ramp_up: assert property (
		op_wr_i && bus_mode_i && en_f == 2'h2 && !st.on |=> st.on && st.ramp_up)
		else $error("enable not taken");
	chk_mode_gate: assert property (
		op_wr_i && !bus_mode_i |=> $stable(st.on) && !st.ramp_up && !st.imm_off && !st.soft_off)
		else $error("enable field acted outside bus mode");
	chk_margin_decode: assert property (
		op_wr_i && mg_f != 2'h3 |=> st.target == oemc_target_t'($past(mg_f)))
		else $error("margin target wrong");
	chk_unsupported_enable: assert property (
		op_wr_i && en_f == 2'h3
		|=> $stable(st.on) && !st.ramp_up && !st.imm_off && !st.soft_off)
		else $error("reserved enable code changed output state");
	chk_unsupported_margin: assert property (
		op_wr_i && mg_f == 2'h3 |=> $stable(st.target))
		else $error("reserved margin code changed target");
	chk_pulse_single: assert property (
		st.imm_off |-> !st.on && !st.ramp_up && !st.soft_off)
		else $error("off pulse inconsistent with state");

	cov_soft_off_seen: cover property (st.soft_off);
	cov_ramp_then_off: cover property (st.ramp_up ##[1:20] st.imm_off);

endmodule : oemc_channel
`default_nettype wire

// >>> hdl/oemc_pkg.sv
`default_nettype none
package oemc_pkg;

	typedef enum logic [1:0] {
		OEMC_TGT_NOMINAL,
		OEMC_TGT_LOW,
		OEMC_TGT_HIGH
	} oemc_target_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] data;
	} oemc_wr_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} oemc_rd_t;

	typedef struct packed {
		logic       ack;
		logic       err;
		logic [7:0] data;
	} oemc_rsp_t;

	typedef struct packed {
		logic         on;
		oemc_target_t target;
		logic         imm_off;
		logic         soft_off;
		logic         ramp_up;
		logic [7:0]   op;
	} oemc_chan_t;

	typedef struct packed {
		logic [7:0] page;
		oemc_rsp_t  rsp;
		logic       wr_err;
	} oemc_top_state_t;

endpackage : oemc_pkg
`default_nettype wire

// >>> hdl/oemc_regs.svh
`ifndef OEMC_REGS_SVH
`define OEMC_REGS_SVH

// Command codes, which are also the register offsets
`define OEMC_CODE_PAGE      8'h00
`define OEMC_CODE_OPERATION 8'h01

// Operation byte fields
`define OEMC_EN_MSB     7
`define OEMC_EN_LSB     6
`define OEMC_MARGIN_MSB 5
`define OEMC_MARGIN_LSB 4

// Enable field encodings
`define OEMC_EN_IMM_OFF  2'h0
`define OEMC_EN_SOFT_OFF 2'h1
`define OEMC_EN_ON       2'h2

// Margin field encodings
`define OEMC_MG_NOMINAL 2'h0
`define OEMC_MG_LOW     2'h1
`define OEMC_MG_HIGH    2'h2

// Page selector values
`define OEMC_PAGE_CH0   8'h00
`define OEMC_PAGE_CH1   8'h01
`define OEMC_PAGE_ALL   8'hFF

// Reset values
`define OEMC_PAGE_RESET 8'h00
`define OEMC_OP_RESET   8'h00
`define OEMC_RD_RESET   8'h00

`endif

// >>> hdl/oemc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "oemc_regs.svh"

module oemc_top (
	input  wire logic                       sys_clk_i,
	input  wire logic                       reset_n_i,
	input  wire oemc_pkg::oemc_wr_t          wr_i,
	input  wire oemc_pkg::oemc_rd_t          rd_i,
	input  wire logic [1:0]                 bus_mode_i,
	output var  oemc_pkg::oemc_rsp_t         rsp_o,
	output var  logic                       wr_err_o,
	output var  logic [7:0]                 page_o,
	output var  oemc_pkg::oemc_chan_t [1:0]  chan_o
);
	import oemc_pkg::*;

	oemc_top_state_t st;
	oemc_top_state_t next_st;
	logic [1:0]      op_wr;
	oemc_chan_t [1:0] chan;

	// Page value selects a single channel or all of them
	function automatic logic page_hits(input logic [7:0] page, input logic idx);
		logic hit;
		hit = (page == `OEMC_PAGE_ALL);
		if (idx) begin
			hit = hit || (page == `OEMC_PAGE_CH1);
		end else begin
			hit = hit || (page == `OEMC_PAGE_CH0);
		end
		return hit;
	endfunction : page_hits

	function automatic logic page_valid(input logic [7:0] page);
		return page_hits(page, 1'b0) || page_hits(page, 1'b1);
	endfunction : page_valid

	// operation writes go to the channel the page picks
	always_comb begin
		op_wr[0] = wr_i.valid && wr_i.code == `OEMC_CODE_OPERATION && page_hits(st.page, 1'b0);
		op_wr[1] = wr_i.valid && wr_i.code == `OEMC_CODE_OPERATION && page_hits(st.page, 1'b1);
	end

	for (genvar g = 0; g < 2; g++) begin : g_chan
		oemc_channel u_chan (
			.sys_clk_i  (sys_clk_i),
			.reset_n_i  (reset_n_i),
			.op_wr_i    (op_wr[g]),
			.op_data_i  (wr_i.data),
			.bus_mode_i (bus_mode_i[g]),
			.chan_o     (chan[g])
		);
	end

	always_comb begin
		next_st          = st;
		next_st.wr_err   = 1'b0;
		next_st.rsp.ack  = 1'b0;
		next_st.rsp.err  = 1'b0;
		next_st.rsp.data = `OEMC_RD_RESET;
		if (wr_i.valid) begin
			unique case (wr_i.code)
				`OEMC_CODE_PAGE: next_st.page = wr_i.data;
				`OEMC_CODE_OPERATION: next_st.wr_err = !page_valid(st.page);
				default: next_st.wr_err = 1'b1;
			endcase
		end
		if (rd_i.valid) begin
			next_st.rsp.ack = 1'b1;
			unique case (rd_i.code)
				`OEMC_CODE_PAGE: next_st.rsp.data = st.page;
				`OEMC_CODE_OPERATION: begin
					if (page_hits(st.page, 1'b0)) begin
						next_st.rsp.data = chan[0].op;
					end else if (page_hits(st.page, 1'b1)) begin
						next_st.rsp.data = chan[1].op;
					end else begin
						next_st.rsp.err = 1'b1;
					end
				end
				default: next_st.rsp.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st <= '{page: `OEMC_PAGE_RESET, rsp: '{ack: 1'b0, err: 1'b0, data: `OEMC_RD_RESET},
				wr_err: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign rsp_o    = st.rsp;
	assign wr_err_o = st.wr_err;
	assign page_o   = st.page;
	assign chan_o   = chan;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_page_store: assert property (
		wr_i.valid && wr_i.code == 8'h00 |=> page_o == $past(wr_i.data))
		else $error("page selector not stored");
	chk_page_route: assert property (
		wr_i.valid && wr_i.code == 8'h01 && page_o == 8'h01
		|=> chan_o[1].op == $past(wr_i.data) && $stable(chan_o[0].op))
		else $error("operation reached wrong channel");
	chk_page_all: assert property (
		wr_i.valid && wr_i.code == 8'h01 && page_o == 8'hFF
		|=> chan_o[0].op == $past(wr_i.data) && chan_o[1].op == $past(wr_i.data))
		else $error("broadcast page missed a channel");
	chk_bad_page: assert property (
		wr_i.valid && wr_i.code == 8'h01 && page_o == 8'h05
		|=> wr_err_o && $stable(chan_o[0].op) && $stable(chan_o[1].op))
		else $error("write to absent page not refused");
	chk_read_back: assert property (
		rd_i.valid && rd_i.code == 8'h00 |=> rsp_o.ack && !rsp_o.err && rsp_o.data == $past(page_o))
		else $error("page read back wrong");
	chk_bus_on_needed: assert property (
		bus_mode_i[0] && !chan_o[0].on && !(op_wr[0] && wr_i.data[7:6] == 2'h2)
		|=> !chan_o[0].on)
		else $error("output enabled without bus on command");
	chk_bus_on_ch1: assert property (
		bus_mode_i[1] && !chan_o[1].on
		&& !(wr_i.valid && wr_i.code == 8'h01 && (page_o == 8'h01 || page_o == 8'hFF)
		&& wr_i.data[7:6] == 2'h2)
		|=> !chan_o[1].on)
		else $error("channel 1 enabled without bus on command");
	chk_bus_gate_ch0: assert property (
		!bus_mode_i[0] |=> !chan_o[0].ramp_up && !chan_o[0].imm_off && !chan_o[0].soft_off)
		else $error("channel 0 enable field acted outside bus mode");
	chk_bus_gate_ch1: assert property (
		!bus_mode_i[1] |=> !chan_o[1].ramp_up && !chan_o[1].imm_off && !chan_o[1].soft_off)
		else $error("channel 1 enable field acted outside bus mode");

	// Write side: routing, holding and refusal
	chk_page_ch0_route: assert property (
		wr_i.valid && wr_i.code == 8'h01 && page_o == 8'h00
		|=> chan_o[0].op == $past(wr_i.data) && $stable(chan_o[1].op))
		else $error("operation for page 0 reached wrong channel");
	chk_page_hold: assert property (
		!(wr_i.valid && wr_i.code == 8'h00) |=> $stable(page_o))
		else $error("page selector changed without a page write");
	chk_op_hold: assert property (
		!(wr_i.valid && wr_i.code == 8'h01) |=> $stable(chan_o[0].op) && $stable(chan_o[1].op))
		else $error("operation byte changed without a write");
	chk_bad_code_write: assert property (
		wr_i.valid && wr_i.code != 8'h00 && wr_i.code != 8'h01
		|=> wr_err_o && $stable(page_o) && $stable(chan_o[0].op) && $stable(chan_o[1].op))
		else $error("write to unmapped code not refused");
	chk_wr_err_cause: assert property (
		wr_err_o |-> $past(wr_i.valid))
		else $error("write error without a write");

	// Read side: one answer per read, from channel 0 under page 0 or all, channel 1 under page 1
	chk_read_ack: assert property (
		rd_i.valid |=> rsp_o.ack)
		else $error("read not answered");
	chk_ack_single: assert property (
		!rd_i.valid |=> !rsp_o.ack && !rsp_o.err && rsp_o.data == 8'h00)
		else $error("answer without a read");
	chk_err_data: assert property (
		rsp_o.err |-> rsp_o.ack && rsp_o.data == 8'h00)
		else $error("refused read carries data");
	chk_read_ch0: assert property (
		rd_i.valid && rd_i.code == 8'h01 && (page_o == 8'h00 || page_o == 8'hFF)
		|=> !rsp_o.err && rsp_o.data == $past(chan_o[0].op))
		else $error("operation read not from channel 0");
	chk_read_ch1: assert property (
		rd_i.valid && rd_i.code == 8'h01 && page_o == 8'h01
		|=> !rsp_o.err && rsp_o.data == $past(chan_o[1].op))
		else $error("operation read not from channel 1");
	chk_read_bad_page: assert property (
		rd_i.valid && rd_i.code == 8'h01
		&& page_o != 8'h00 && page_o != 8'h01 && page_o != 8'hFF
		|=> rsp_o.ack && rsp_o.err)
		else $error("read under absent page not refused");
	chk_read_bad_code: assert property (
		rd_i.valid && rd_i.code != 8'h00 && rd_i.code != 8'h01
		|=> rsp_o.ack && rsp_o.err)
		else $error("read of unmapped code not refused");

	cov_page1_on: cover property (page_o == 8'h01 ##1 chan_o[1].ramp_up);
	cov_margin_high: cover property (chan_o[0].target == OEMC_TGT_HIGH && chan_o[0].on);
	cov_read_op: cover property (rsp_o.ack && !rsp_o.err);

endmodule : oemc_top
`default_nettype wire

// >>> testbench/oemc_host.sv
`timescale 1ns/100ps
`default_nettype none
module oemc_host (
	input  wire logic               sys_clk_i,
	output var  oemc_pkg::oemc_wr_t wr_o,
	output var  oemc_pkg::oemc_rd_t rd_o
);
	import oemc_pkg::*;
	initial begin
		wr_o = '0;
		rd_o = '0;
	end
	// Held to the taking edge, then released lines show inverted bytes
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1 wr_o <= {1'b1, c, d};
		@(posedge sys_clk_i);
		#1 wr_o <= {1'b0, ~c, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] c);
		@(posedge sys_clk_i);
		#1 rd_o <= {1'b1, c};
		@(posedge sys_clk_i);
		#1 rd_o <= {1'b0, ~c};
	endtask : rd
endmodule : oemc_host
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "oemc_regs.svh"
module testbench;
	import oemc_pkg::*;
	localparam logic [7:0] PG = `OEMC_CODE_PAGE;
	localparam logic [7:0] OP = `OEMC_CODE_OPERATION;
	logic             sys_clk = 1'b0;
	logic             reset_n = 1'b0;
	logic [1:0]       bus_mode = 2'b00;
	oemc_wr_t         wr;
	oemc_rd_t         rd;
	oemc_rsp_t        rsp;
	logic             wr_err;
	logic [7:0]       page;
	oemc_chan_t [1:0] chan;
	logic [8:0]       expq[$];
	logic [8:0]       e;
	logic [7:0]       d;
	int               n_fail = 0;
	int               checks = 0;
	int unsigned      r;
	always #10 sys_clk = ~sys_clk;
	oemc_host i_host (.sys_clk_i(sys_clk), .wr_o(wr), .rd_o(rd));
	oemc_top i_dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .wr_i(wr), .rd_i(rd),
		.bus_mode_i(bus_mode), .rsp_o(rsp), .wr_err_o(wr_err), .page_o(page), .chan_o(chan));
	function automatic logic [13:0] mk(input logic [5:0] f, input logic [7:0] o);
		return {f, o};
	endfunction : mk
	task automatic chk(input logic [13:0] ex, input logic [13:0] got);
		checks++;
		if (ex !== got) begin
			n_fail++;
			$display("unexpected at %0t: exp %h got %h", $time, ex, got);
		end
	endtask : chk
	task automatic chk_rsp(input logic [8:0] ex, input logic [8:0] got);
		checks++;
		if (ex !== got) begin
			n_fail++;
			$display("unexpected read at %0t: exp %h got %h", $time, ex, got);
		end
	endtask : chk_rsp
	task automatic rd_exp(input logic [7:0] c, input logic [8:0] ex);
		expq.push_back(ex);
		i_host.rd(c);
	endtask : rd_exp
	// Read answers are matched in order of issue
	always @(negedge sys_clk) begin
		if (rsp.ack === 1'b1) begin
			if (expq.size() == 0) begin
				chk_rsp(9'h1FF, {rsp.err, rsp.data});
			end else begin
				e = expq.pop_front();
				chk_rsp(e, {rsp.err, rsp.data});
			end
		end
	end
	task automatic final_report;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	initial begin
		r = $urandom(32'h4102f5e1);
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		chk(mk(6'h00, 8'h00), chan[0]);
		chk(14'h0000, {6'h00, page});
		bus_mode = 2'b11;
		i_host.wr(PG, 8'h01);
		chk(14'h0001, {6'h00, page});
		rd_exp(PG, 9'h001);
		i_host.wr(OP, 8'h80);
		chk(mk(6'b100001, 8'h80), chan[1]);
		chk(mk(6'h00, 8'h00), chan[0]);
		rd_exp(OP, 9'h080);
		i_host.wr(OP, 8'h00);
		chk(mk(6'b000100, 8'h00), chan[1]);
		i_host.wr(OP, 8'h80);
		i_host.wr(OP, 8'h40);
		chk(mk(6'b000010, 8'h40), chan[1]);
		$display("test on_off done");
		i_host.wr(OP, 8'h80);
		for (int m = 0; m < 3; m++) begin
			i_host.wr(OP, {2'b10, 2'(m), 4'h0});
			chk(mk({1'b1, 2'(m), 3'b000}, {2'b10, 2'(m), 4'h0}), chan[1]);
		end
		i_host.wr(OP, 8'hB0);
		chk(mk(6'b110000, 8'hB0), chan[1]);
		i_host.wr(OP, 8'hE0);
		chk(mk(6'b110000, 8'hE0), chan[1]);
		bus_mode = 2'b00;
		i_host.wr(OP, 8'h00);
		chk(mk(6'b100000, 8'h00), chan[1]);
		$display("test margin done");
		bus_mode = 2'b11;
		i_host.wr(PG, 8'hFF);
		i_host.wr(OP, 8'h90);
		chk(mk(6'b101001, 8'h90), chan[0]);
		chk(mk(6'b101000, 8'h90), chan[1]);
		rd_exp(OP, 9'h090);
		i_host.wr(PG, 8'h05);
		i_host.wr(OP, 8'h00);
		chk(14'h1, {13'h0, wr_err});
		chk(mk(6'b101000, 8'h90), chan[0]);
		rd_exp(OP, 9'h100);
		rd_exp(8'h7E, 9'h100);
		i_host.wr(8'h33, 8'h00);
		chk(14'h1, {13'h0, wr_err});
		i_host.wr(PG, 8'hFF);
		bus_mode = 2'b01;
		i_host.wr(OP, 8'h10);
		chk(mk(6'b001100, 8'h10), chan[0]);
		chk(mk(6'b101000, 8'h10), chan[1]);
		$display("test page done");
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		bus_mode = 2'b11;
		chk(mk(6'h00, `OEMC_OP_RESET), chan[1]);
		chk({6'h00, `OEMC_PAGE_RESET}, {6'h00, page});
		$display("test reset done");
		i_host.wr(PG, 8'h00);
		repeat (4) begin
			r = $urandom;
			d = {2'(r % 3), 2'((r / 3) % 3), 4'(r)};
			i_host.wr(OP, d);
			chk({3'h0, d[7:6] == `OEMC_EN_ON, d[5:4], d},
				{3'h0, chan[0].on, chan[0].target, chan[0].op});
			rd_exp(OP, {1'b0, d});
		end
		repeat (3) @(posedge sys_clk);
		chk(14'(expq.size()), 14'h0);
		$display("test random done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
